/* File: verilog/brk_cycle_pkg.sv */
// Package: register map, field layout and bus-cycle types of the block
package brk_cycle_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets on APB
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CHAN_A_ADDR_MASK   = 8'h00;
    localparam logic [7:0] OFS_CHAN_B_ADDR_MASK   = 8'h04;
    localparam logic [7:0] OFS_CHAN_A_CYCLE_COND  = 8'h08;
    localparam logic [7:0] OFS_CHAN_B_CYCLE_COND  = 8'h0C;
    localparam logic [7:0] OFS_CHAN_B_CMP_DATA    = 8'h10;
    localparam logic [7:0] OFS_CHAN_B_CMP_MASK    = 8'h14;
    localparam logic [7:0] OFS_BREAK_CONTROL      = 8'h18;
    localparam logic [7:0] OFS_MATCH_STATUS       = 8'h1C;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int CC_TYPE_HI      = 5;
    localparam int CC_TYPE_LO      = 4;
    localparam int CC_DIR_HI       = 3;
    localparam int CC_DIR_LO       = 2;
    localparam int CC_SIZE_HI      = 1;
    localparam int CC_SIZE_LO      = 0;
    localparam int CC_WIDTH        = 6;
    localparam int AM_WIDTH        = 3;
    localparam int AM_ASID_BIT     = 2;
    localparam int BC_DATA_EN_BIT  = 7;
    localparam int BC_WIDTH        = 16;
    localparam logic [15:0] CYCLE_COND_RESET = 16'h0000;
    localparam logic [15:0] BREAK_CTRL_RESET = 16'h0000;
    localparam logic [31:0] READ_ZERO        = 32'h0000_0000;

    // Field encodings
    localparam logic [1:0] SEL_NONE  = 2'h0;
    localparam logic [1:0] SEL_FIRST = 2'h1;
    localparam logic [1:0] SEL_SECND = 2'h2;
    localparam logic [1:0] SEL_BOTH  = 2'h3;
    localparam logic [1:0] SIZE_ANY  = 2'h0;
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] SIZE_LONG = 2'h3;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic        is_fetch;
        logic        is_write;
        logic [1:0]  size;
        logic [31:0] data;
    } bus_cycle_t;

    typedef struct packed {
        logic [1:0] cycle_type_sel;
        logic [1:0] direction_sel;
        logic [1:0] size_sel;
    } cycle_cond_t;

endpackage

/* File: verilog/break_bus_cycle_data_match.sv */
// Bus-cycle comparison for two breakpoint channels, data comparison for channel B only, APB slave
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none

module break_bus_cycle_data_match
(
    // Clock and reset
    input  wire logic                     clock_in,
    input  wire logic                     sys_rst_in,
    // APB slave
    input  wire logic                     psel_in,
    input  wire logic                     penable_in,
    input  wire logic                     pwrite_in,
    input  wire logic [7:0]               paddr_in,
    input  wire logic [31:0]              pwdata_in,
    output logic      [31:0]              prdata_out,
    output logic                          pready_out,
    output logic                          pslverr_out,
    // Processor bus cycle
    input  wire brk_cycle_pkg::bus_cycle_t cycle_in,
    // Match results and settings for the address/trap logic
    output logic                          match_a_out,
    output logic                          match_b_out,
    output logic      [2:0]               chan_a_addr_mask_out,
    output logic      [2:0]               chan_b_addr_mask_out
);
    import brk_cycle_pkg::*;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    cycle_cond_t        cond_r [2];
    logic [AM_WIDTH-1:0] amask_r [2];
    logic [31:0]        cmp_data_r;
    logic [31:0]        cmp_mask_r;
    logic               data_en_r;
    logic               match_a_r;
    logic               match_b_r;
    logic [31:0]        rdata_nxt;
    logic               addr_ok;
    logic               wr_en;
    logic               rd_en;

    // Access phase of APB, answered with zero wait states
    assign wr_en = psel_in && penable_in && pwrite_in;
    assign rd_en = psel_in && penable_in && !pwrite_in;

    // Decode used for the error answer only; read data decodes in its own case
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == OFS_CHAN_A_ADDR_MASK) || (a == OFS_CHAN_B_ADDR_MASK)
              || (a == OFS_CHAN_A_CYCLE_COND) || (a == OFS_CHAN_B_CYCLE_COND)
              || (a == OFS_CHAN_B_CMP_DATA)  || (a == OFS_CHAN_B_CMP_MASK)
              || (a == OFS_BREAK_CONTROL)    || (a == OFS_MATCH_STATUS);
    endfunction

    assign addr_ok = mapped(paddr_in);

    // Cycle condition registers, one per channel
    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            cond_r[0] <= cycle_cond_t'(CYCLE_COND_RESET[CC_WIDTH-1:0]);
            cond_r[1] <= cycle_cond_t'(CYCLE_COND_RESET[CC_WIDTH-1:0]);
        end
        else if (wr_en && paddr_in == OFS_CHAN_A_CYCLE_COND)
            cond_r[0] <= cycle_cond_t'(pwdata_in[CC_WIDTH-1:0]);
        else if (wr_en && paddr_in == OFS_CHAN_B_CYCLE_COND)
            cond_r[1] <= cycle_cond_t'(pwdata_in[CC_WIDTH-1:0]);
    end

    // Address masks, data registers: no reset, contents kept over reset
    always_ff @(posedge clock_in)
    begin
        if (wr_en && paddr_in == OFS_CHAN_A_ADDR_MASK)
            amask_r[0] <= pwdata_in[AM_WIDTH-1:0];
        if (wr_en && paddr_in == OFS_CHAN_B_ADDR_MASK)
            amask_r[1] <= pwdata_in[AM_WIDTH-1:0];
        if (wr_en && paddr_in == OFS_CHAN_B_CMP_DATA)
            cmp_data_r <= pwdata_in;
        if (wr_en && paddr_in == OFS_CHAN_B_CMP_MASK)
            cmp_mask_r <= pwdata_in;
    end

    // Data-compare enable in the control word
    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            data_en_r <= BREAK_CTRL_RESET[BC_DATA_EN_BIT];
        else if (wr_en && paddr_in == OFS_BREAK_CONTROL)
            data_en_r <= pwdata_in[BC_DATA_EN_BIT];
    end

    // ------------------------------------------------------------------
    // Comparison
    // ------------------------------------------------------------------
    // Two-bit selects: bit 0 picks the first kind, bit 1 the second
    function automatic logic sel_hit(input logic [1:0] sel,
                                     input logic       second);
        sel_hit = second ? sel[1] : sel[0];
    endfunction

    function automatic logic cond_hit(input cycle_cond_t c,
                                      input bus_cycle_t  b);
        logic t_ok;
        logic d_ok;
        logic s_ok;
        t_ok = sel_hit(c.cycle_type_sel, !b.is_fetch);
        d_ok = sel_hit(c.direction_sel, b.is_write);
        s_ok = (c.size_sel == SIZE_ANY) || (c.size_sel == b.size);
        // A zero type or direction field never hits
        cond_hit = b.valid && t_ok && d_ok && s_ok;
    endfunction

    // Masked data compare; upper half dropped for byte and word sizes
    function automatic logic data_hit(input logic [31:0] d,
                                      input logic [31:0] ref_v,
                                      input logic [31:0] msk,
                                      input logic [1:0]  sz);
        logic [31:0] care;
        care = ~msk;
        if (sz == SIZE_BYTE || sz == SIZE_WORD)
            care[31:16] = 16'h0000;
        data_hit = ((d ^ ref_v) & care) == 32'h0000_0000;
    endfunction

    logic hit_a;
    logic hit_b;
    logic use_data;
    // Size used for the data lanes is the programmed one, else the cycle's
    logic [1:0] data_size;

    assign hit_a     = cond_hit(cond_r[0], cycle_in);
    assign use_data  = data_en_r && !cycle_in.is_fetch;
    assign data_size = (cond_r[1].size_sel == SIZE_ANY) ? cycle_in.size
                                                        : cond_r[1].size_sel;
    assign hit_b     = cond_hit(cond_r[1], cycle_in)
                    && (!use_data
                        || data_hit(cycle_in.data, cmp_data_r,
                                    cmp_mask_r, data_size));

    // Match outputs are registered: one cycle after the bus cycle
    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            match_a_r <= 1'b0;
            match_b_r <= 1'b0;
        end
        else
        begin
            match_a_r <= hit_a;
            match_b_r <= hit_b;
        end
    end

    assign match_a_out = match_a_r;
    assign match_b_out = match_b_r;

    // ------------------------------------------------------------------
    // Read data and answer
    // ------------------------------------------------------------------
    always_comb
    begin
        rdata_nxt = READ_ZERO;
        case (paddr_in)
            OFS_CHAN_A_ADDR_MASK:  rdata_nxt[AM_WIDTH-1:0] = amask_r[0];
            OFS_CHAN_B_ADDR_MASK:  rdata_nxt[AM_WIDTH-1:0] = amask_r[1];
            OFS_CHAN_A_CYCLE_COND: rdata_nxt[CC_WIDTH-1:0] = cond_r[0];
            OFS_CHAN_B_CYCLE_COND: rdata_nxt[CC_WIDTH-1:0] = cond_r[1];
            OFS_CHAN_B_CMP_DATA:   rdata_nxt = cmp_data_r;
            OFS_CHAN_B_CMP_MASK:   rdata_nxt = cmp_mask_r;
            OFS_BREAK_CONTROL:     rdata_nxt[BC_DATA_EN_BIT] = data_en_r;
            OFS_MATCH_STATUS:      rdata_nxt[1:0] = {match_b_r, match_a_r};
            default:               rdata_nxt = READ_ZERO;
        endcase
    end

    // Answer registered in setup so it stands throughout the access phase
    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            prdata_out  <= READ_ZERO;
            pslverr_out <= 1'b0;
        end
        else if (psel_in && !penable_in)
        begin
            prdata_out  <= pwrite_in ? READ_ZERO : rdata_nxt;
            pslverr_out <= !addr_ok;
        end
    end

    // Ready high in every access phase: one setup plus one access cycle
    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            pready_out <= 1'b0;
        else
            pready_out <= psel_in && !penable_in;
    end

    // Mask settings forwarded to the address comparator
    always_ff @(posedge clock_in)
    begin
        chan_a_addr_mask_out <= amask_r[0];
        chan_b_addr_mask_out <= amask_r[1];
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_write_b_cond;
        wr_en && paddr_in == OFS_CHAN_B_CYCLE_COND;
    endsequence

    a_reserved_read_zero: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (psel_in && !penable_in && !pwrite_in
         && paddr_in == OFS_CHAN_A_CYCLE_COND) |=> prdata_out[15:6] == 10'h000)
        else $error("reserved bits of cycle condition read non-zero");

    a_cond_b_written: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        s_write_b_cond |=> cond_r[1] == $past(pwdata_in[CC_WIDTH-1:0]))
        else $error("channel B condition write lost");

    a_zero_type_silent: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (cond_r[0].cycle_type_sel == SEL_NONE
         || cond_r[0].direction_sel == SEL_NONE) |=> !match_a_out)
        else $error("channel A matched with a zero field");

    a_fetch_no_data: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (cond_hit(cond_r[1], cycle_in) && cycle_in.is_fetch) |=> match_b_out)
        else $error("fetch match on channel B blocked by data");

    a_data_disabled: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (cond_hit(cond_r[1], cycle_in) && !data_en_r) |=> match_b_out)
        else $error("data compared while disabled");

    a_mask_all_hits: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (cond_hit(cond_r[1], cycle_in) && cmp_mask_r == 32'hFFFF_FFFF)
        |=> match_b_out)
        else $error("fully masked data blocked a match");

    a_upper_ignored: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (cond_hit(cond_r[1], cycle_in) && cycle_in.size == SIZE_WORD
         && ((cycle_in.data[15:0] ^ cmp_data_r[15:0]) & ~cmp_mask_r[15:0])
            == 16'h0000) |=> match_b_out)
        else $error("upper half compared for word size");

    a_match_needs_all: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        match_a_out |-> $past(cycle_in.valid)
                     && ($past(cycle_in.size) == $past(cond_r[0].size_sel)
                         || $past(cond_r[0].size_sel) == SIZE_ANY))
        else $error("channel A matched without all conditions");

    a_reset_clear: assert property (@(posedge clock_in)
        $fell(sys_rst_in) |-> cond_r[0] == cycle_cond_t'(CYCLE_COND_RESET[CC_WIDTH-1:0]))
        else $error("channel A condition not cleared by reset");

endmodule

`default_nettype wire

/* File: test/core_cycle_model.sv */
// Behavioural model of the processor core issuing internal bus cycles
`timescale 1ns/1ps
`default_nettype none

module core_cycle_model
    import brk_cycle_pkg::*;
(
    // Clock and reset
    input  wire logic       clock_in,
    input  wire logic       sys_rst_in,
    // Request from the bench
    input  wire logic       req_in,
    input  wire bus_cycle_t req_cycle_in,
    // Bus cycle towards the block
    output var  bus_cycle_t cycle_out
);
    // One cycle per request; idle cycles clear valid and scramble direction and data so that
    // stale data can never pose as a valid cycle
    always_ff @(posedge clock_in or posedge sys_rst_in)
        if (sys_rst_in)
            cycle_out <= '0;
        else if (req_in)
            cycle_out <= req_cycle_in;
        else
        begin
            cycle_out.valid    <= 1'b0;
            cycle_out.is_write <= ~cycle_out.is_write;
            cycle_out.data     <= ~cycle_out.data;
        end
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench for the breakpoint bus-cycle and data match block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import brk_cycle_pkg::*;
    logic        clock_in, sys_rst_in, psel, penable, pwrite, cyc_req;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, d, m, x;
    logic        pready, pslverr, er, match_a, match_b, en;
    logic [2:0]  am_a, am_b;
    logic [5:0]  cca, ccb;
    bus_cycle_t  cyc_d, cyc, c;
    int          errors, n_checks, seed, i;
    logic [7:0]  ra [4] = '{8'h00, 8'h04, 8'h08, 8'h0C};
    logic [31:0] rm [4] = '{32'h7, 32'h7, 32'h3F, 32'h3F};

    break_bus_cycle_data_match i_break_bus_cycle_data_match (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .cycle_in(cyc), .match_a_out(match_a),
        .match_b_out(match_b), .chan_a_addr_mask_out(am_a),
        .chan_b_addr_mask_out(am_b));
    core_cycle_model i_core_cycle_model (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .req_in(cyc_req),
        .req_cycle_in(cyc_d), .cycle_out(cyc));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, exp, input string s);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: %s seen %h expected %h",
                     $time, s, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // APB transfer; holds the request until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clock_in);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w;
        paddr <= a; pwdata <= wd;
        @(posedge clock_in);
        penable <= 1'b1;
        do
        begin
            @(posedge clock_in);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        if (n >= 50)
            errors++;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // Expected hit: data lanes follow programmed size, else cycle size
    function automatic logic hit(logic [5:0] cc, bus_cycle_t b,
                                 logic use_d, logic [31:0] dd, mm);
        logic [1:0]  sz;
        logic [31:0] ln;
        logic        ok;
        ok = (b.is_fetch ? cc[4] : cc[5]) && (b.is_write ? cc[3] : cc[2])
             && (cc[1:0] == SIZE_ANY || cc[1:0] == b.size);
        sz = (cc[1:0] != SIZE_ANY) ? cc[1:0] : b.size;
        ln = (sz == SIZE_LONG) ? 32'hFFFF_FFFF : 32'h0000_FFFF;
        if (use_d && !b.is_fetch && (((b.data ^ dd) & ~mm & ln) != 0))
            ok = 1'b0;
        return ok;
    endfunction

    // Clock at 40 MHz
    initial
    begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end

    // Watchdog against a hung handshake
    initial
    begin
        #(25 * 40000);
        errors++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        seed = 39; errors = 0; n_checks = 0; sys_rst_in = 1'b1;
        psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        cyc_req = 0; cyc_d = '0;
        repeat (8) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        apb(0, OFS_CHAN_A_CYCLE_COND, 0); check(rd, 0, "a rst");
        apb(0, OFS_CHAN_B_CYCLE_COND, 0); check(rd, 0, "b rst");
        // Reserved bits must read back zero after an all-ones write
        for (i = 0; i < 4; i++)
        begin
            apb(1, ra[i], 32'hFFFF_FFFF);
            apb(0, ra[i], 0);
            check(rd, rm[i], "rw mask");
        end
        @(negedge clock_in);
        check({am_b, am_a}, 32'h3F, "mask outs");
        apb(1, 8'h20, 32'hFFFF_FFFF); check(er, 1, "unmapped wr");
        apb(0, 8'h20, 0); check({er, rd}, 33'h1_0000_0000, "unmapped rd");
        // Compare data survives a reset, cycle condition does not
        x = $random(seed);
        apb(1, OFS_CHAN_B_CMP_DATA, x);
        @(posedge clock_in) sys_rst_in <= 1'b1;
        @(posedge clock_in) sys_rst_in <= 1'b0;
        apb(0, OFS_CHAN_B_CMP_DATA, 0); check(rd, x, "data keep");
        apb(0, OFS_CHAN_A_CYCLE_COND, 0); check(rd, 0, "cc rst");
        // Random settings and cycles, biased towards data hits
        for (i = 0; i < 300; i++)
        begin
            cca = $random(seed); ccb = $random(seed); en = $random(seed);
            d = $random(seed); m = $random(seed) & $random(seed);
            if (ccb[1:0] == SIZE_BYTE)
            begin
                d[15:8] = d[7:0];
                m[15:8] = m[7:0];
            end
            apb(1, OFS_CHAN_A_CYCLE_COND, {26'h0, cca});
            apb(1, OFS_CHAN_B_CYCLE_COND, {26'h0, ccb});
            apb(1, OFS_CHAN_B_CMP_DATA, d);
            apb(1, OFS_CHAN_B_CMP_MASK, m);
            apb(1, OFS_BREAK_CONTROL, {24'h0, en, 7'h0});
            x = $random(seed);
            c.valid = 1'b1; c.is_fetch = x[2]; c.is_write = x[3];
            c.size = x[5:4] == 2'h0 ? SIZE_LONG : x[5:4];
            c.data = x[0] ? d ^ ($random(seed) & m)
                     ^ (x[1] ? {x[31:16], 16'h0} : 32'h0) : $random(seed);
            if (c.size == SIZE_BYTE)
                c.data[15:8] = c.data[7:0];
            @(posedge clock_in);
            cyc_req <= 1'b1; cyc_d <= c;
            @(posedge clock_in) cyc_req <= 1'b0;
            @(posedge clock_in);
            @(negedge clock_in);
            check(match_a, hit(cca, c, 0, d, m), "a");
            check(match_b, hit(ccb, c, en, d, m), "b");
            @(negedge clock_in);
            check({match_b, match_a}, 0, "pulse");
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
